// ===== ccdrd_defines.vh
`ifndef CCDRD_DEFINES_VH
`define CCDRD_DEFINES_VH

// Frame geometry
`define CCDRD_COLS_TOTAL      3088
`define CCDRD_ROWS_TOTAL      2056
`define CCDRD_COLS_ACTIVE     3072
`define CCDRD_ROWS_ACTIVE     2048
`define CCDRD_HREG_LEN        3100
`define CCDRD_DARK_LEAD_COLS  6
`define CCDRD_DARK_TRAIL_COLS 10
`define CCDRD_DARK_LEAD_ROWS  4
`define CCDRD_DARK_TRAIL_ROWS 4
`define CCDRD_DUMMY_LEAD      10
`define CCDRD_DUMMY_TRAIL     2
`define CCDRD_SCAVENGE_LINES  2

// Phase timing, core cycles per half phase
`define CCDRD_V_HALF          4
`define CCDRD_H_HALF          2

// Counter widths
`define CCDRD_CW              12
`define CCDRD_TW              4

`endif

// ===== ccdrd_count.v
`timescale 1ns/1ns
// Wrap counter with terminal flag; shared by pixel and line counting
module ccdrd_count #(
	parameter W   = 12,
	parameter MAX = 12'hFFF
) (
	// Clock and reset
	input  wire         core_clk,
	input  wire         rst,
	// Control
	input  wire         clear,
	input  wire         step,
	// Status
	output reg  [W-1:0] value_reg,
	output wire         last
);
	reg [W-1:0] value_next;

	assign last = (value_reg == MAX);

	always @* begin
		value_next = value_reg;
		if (clear)
			value_next = {W{1'b0}};
		else if (step)
			value_next = last ? {W{1'b0}} : value_reg + {{(W-1){1'b0}}, 1'b1};
	end

	always @(posedge core_clk) begin
		if (rst)
			value_reg <= {W{1'b0}};
		else
			value_reg <= value_next;
	end
endmodule // ccdrd_count

// ===== ccdrd_seq.v
`timescale 1ns/1ns
`include "ccdrd_defines.vh"
//Contract
//- Dark pixels beside active ones and first two lines are not references.
//- Both vertical phases stay low throughout integration.
//- Line enters horizontal register on vertical two fall, horizontal one held high.
//- Horizontal phases toggle alternately, always complementary.
//- Reset gate pulses only after the pixel output has been sampled.
module ccdrd_seq #(
	parameter ROWS  = `CCDRD_ROWS_TOTAL,
	parameter HLEN  = `CCDRD_HREG_LEN,
	parameter VHALF = `CCDRD_V_HALF,
	parameter HHALF = `CCDRD_H_HALF,
	parameter DW    = 12
) (
	// Clock and reset
	input  wire          core_clk,
	input  wire          rst,
	// User control
	input  wire          frame_start,
	output wire          busy,
	// Sensor phase pins
	output reg           vertical_phase_one,
	output reg           vertical_phase_two,
	output reg           horizontal_phase_one,
	output reg           horizontal_phase_two,
	output reg           reset_gate,
	// Sampled video from external converter
	input  wire [DW-1:0] video_sample,
	// Pixel stream
	output reg  [DW-1:0] pix_data,
	output reg           pix_valid,
	output reg           pix_active,
	output reg           pix_dark_ref,
	output reg           pix_first,
	output reg           line_last
);
	localparam S_IDLE  = 3'h0;
	localparam S_V1    = 3'h1;
	localparam S_V2    = 3'h2;
	localparam S_V2F   = 3'h3;
	localparam S_HHI   = 3'h4;
	localparam S_HLO   = 3'h5;
	localparam S_RST   = 3'h6;

	// Integer forms, cut to counter width below on purpose
	localparam integer HMAX_I   = HLEN - 1;
	localparam integer VMAX_I   = ROWS - 1;
	localparam integer VHMAX_I  = VHALF - 1;
	localparam integer HHMAX_I  = HHALF - 1;
	localparam integer ACT_C0_I = `CCDRD_DUMMY_LEAD + `CCDRD_DARK_LEAD_COLS;
	localparam integer ACT_C1_I = `CCDRD_DUMMY_LEAD + `CCDRD_DARK_LEAD_COLS + `CCDRD_COLS_ACTIVE;
	localparam integer COL_E_I  = `CCDRD_DUMMY_LEAD + `CCDRD_COLS_TOTAL;
	localparam integer ACT_R0_I = `CCDRD_DARK_LEAD_ROWS;
	localparam integer ACT_R1_I = `CCDRD_DARK_LEAD_ROWS + `CCDRD_ROWS_ACTIVE;
	localparam integer SCAV_R_I = `CCDRD_SCAVENGE_LINES;

	localparam [`CCDRD_CW-1:0] HMAX  = HMAX_I[`CCDRD_CW-1:0];
	localparam [`CCDRD_CW-1:0] VMAX  = VMAX_I[`CCDRD_CW-1:0];
	localparam [`CCDRD_TW-1:0] VHMAX = VHMAX_I[`CCDRD_TW-1:0];
	localparam [`CCDRD_TW-1:0] HHMAX = HHMAX_I[`CCDRD_TW-1:0];
	// Column boundaries inside the horizontal register, then row boundaries in the frame
	localparam [`CCDRD_CW-1:0] ACT_C0 = ACT_C0_I[`CCDRD_CW-1:0];
	localparam [`CCDRD_CW-1:0] ACT_C1 = ACT_C1_I[`CCDRD_CW-1:0];
	localparam [`CCDRD_CW-1:0] COL_E  = COL_E_I[`CCDRD_CW-1:0];
	localparam [`CCDRD_CW-1:0] ACT_R0 = ACT_R0_I[`CCDRD_CW-1:0];
	localparam [`CCDRD_CW-1:0] ACT_R1 = ACT_R1_I[`CCDRD_CW-1:0];
	localparam [`CCDRD_CW-1:0] SCAV_R = SCAV_R_I[`CCDRD_CW-1:0];
	localparam [`CCDRD_CW-1:0] ONE    = 12'h001;

	reg  [2:0]            state_reg;
	reg  [2:0]            state_next;
	reg  [`CCDRD_TW-1:0]  tick_reg;
	wire                  tick_clr;
	wire                  vhalf_done = (tick_reg == VHMAX);
	wire                  hhalf_done = (tick_reg == HHMAX);
	wire [`CCDRD_CW-1:0]  col;
	wire [`CCDRD_CW-1:0]  row;
	wire                  col_last;
	wire                  row_last;
	reg                   col_step;
	reg                   row_step;
	wire                  new_frame = (state_reg == S_IDLE) && frame_start;

	assign busy     = (state_reg != S_IDLE);
	assign tick_clr = (state_reg != state_next);

	ccdrd_count #(.W(`CCDRD_CW), .MAX(HMAX)) u_col (
		.core_clk  (core_clk),
		.rst       (rst),
		.clear     (new_frame),
		.step      (col_step),
		.value_reg (col),
		.last      (col_last)
	);

	ccdrd_count #(.W(`CCDRD_CW), .MAX(VMAX)) u_row (
		.core_clk  (core_clk),
		.rst       (rst),
		.clear     (new_frame),
		.step      (row_step),
		.value_reg (row),
		.last      (row_last)
	);

	always @* begin
		state_next = state_reg;
		col_step   = 1'b0;
		row_step   = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (frame_start)
					state_next = S_V1;
			end
			S_V1: begin
				if (vhalf_done)
					state_next = S_V2;
			end
			S_V2: begin
				if (vhalf_done)
					state_next = S_V2F;
			end
			S_V2F: begin
				// V2 has fallen with H1 high; line now in horizontal register
				if (vhalf_done)
					state_next = S_HLO;
			end
			S_HLO: begin
				if (hhalf_done)
					state_next = S_HHI;
			end
			S_HHI: begin
				// H2 fell on entry, so the packet already sits on the node
				if (hhalf_done)
					state_next = S_RST;
			end
			S_RST: begin
				// Sample taken on entry, reset gate pulses afterwards
				if (hhalf_done) begin
					col_step = 1'b1;
					if (!col_last)
						state_next = S_HLO;
					else begin
						row_step   = 1'b1;
						state_next = row_last ? S_IDLE : S_V1;
					end
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	always @(posedge core_clk) begin
		if (rst) begin
			state_reg <= S_IDLE;
			tick_reg  <= {`CCDRD_TW{1'b0}};
		end else begin
			state_reg <= state_next;
			tick_reg  <= tick_clr ? {`CCDRD_TW{1'b0}} : tick_reg + {{(`CCDRD_TW-1){1'b0}}, 1'b1};
		end
	end

	// Phase pins registered from next state, so no glitches
	always @(posedge core_clk) begin
		if (rst) begin
			vertical_phase_one   <= 1'b0;
			vertical_phase_two   <= 1'b0;
			horizontal_phase_one <= 1'b1;
			horizontal_phase_two <= 1'b0;
			reset_gate           <= 1'b0;
		end else begin
			vertical_phase_one   <= (state_next == S_V1);
			vertical_phase_two   <= (state_next == S_V2);
			// H1 held high through the vertical transfer and idle
			horizontal_phase_one <= (state_next != S_HLO);
			// Exact complement; its fall ahead of the sample moves the packet
			horizontal_phase_two <= (state_next == S_HLO);
			reset_gate           <= (state_next == S_RST) && (tick_clr == 1'b0) && busy;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			pix_data     <= {DW{1'b0}};
			pix_valid    <= 1'b0;
			pix_active   <= 1'b0;
			pix_dark_ref <= 1'b0;
			pix_first    <= 1'b0;
			line_last    <= 1'b0;
		end else begin
			pix_valid <= (state_reg == S_HHI) && (state_next == S_RST);
			if ((state_reg == S_HHI) && (state_next == S_RST)) begin
				// Inverted so larger charge yields larger code
				pix_data   <= ~video_sample;
				pix_active <= (col >= ACT_C0) && (col < ACT_C1) && (row >= ACT_R0) && (row < ACT_R1);
				// Usable dark: real columns not adjacent to active, past first lines
				pix_dark_ref <= (row >= SCAV_R) && (col >= `CCDRD_DUMMY_LEAD) && (col < COL_E) &&
				                (col != ACT_C0 - ONE) && (col != ACT_C1) &&
				                (row != ACT_R0 - ONE) && (row != ACT_R1) &&
				                !((col >= ACT_C0) && (col < ACT_C1) && (row >= ACT_R0) && (row < ACT_R1));
				pix_first  <= (col == {`CCDRD_CW{1'b0}}) && (row == {`CCDRD_CW{1'b0}});
				line_last  <= col_last;
			end
		end
	end
endmodule // ccdrd_seq

// ===== ccdrd_seq_asserts.sv
`timescale 1ns/1ns
module ccdrd_seq_asserts (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Control
	input wire frame_start,
	input wire busy,
	// Phase pins
	input wire vertical_phase_one,
	input wire vertical_phase_two,
	input wire horizontal_phase_one,
	input wire horizontal_phase_two,
	input wire reset_gate,
	// Stream
	input wire pix_valid,
	input wire line_last
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_idle_vert_low: assert property (!busy |-> !vertical_phase_one && !vertical_phase_two)
		else $error("vertical moved idle");
	a_entry_h1_high: assert property ($fell(vertical_phase_two) |-> horizontal_phase_one)
		else $error("line entry with h1 low");
	a_h_complement: assert property (horizontal_phase_two != horizontal_phase_one)
		else $error("h phases not complementary");
	a_h_low_span: assert property ($fell(horizontal_phase_one) |-> !horizontal_phase_one[*2] ##1 horizontal_phase_one)
		else $error("h1 low span");
	a_v_no_overlap: assert property (!(vertical_phase_one && vertical_phase_two))
		else $error("v phases overlap");
	a_v1_span: assert property ($rose(vertical_phase_one) |-> vertical_phase_one[*4] ##1 (!vertical_phase_one && vertical_phase_two))
		else $error("v1 span");
	a_v_holds_h1: assert property (vertical_phase_one || vertical_phase_two |-> horizontal_phase_one)
		else $error("h shift during transfer");
	a_rg_after_sample: assert property ($rose(reset_gate) |-> (pix_valid || $past(pix_valid)) ##1 !reset_gate)
		else $error("reset gate before sample");
	a_start_v1: assert property (frame_start && !busy |-> ##[1:2] vertical_phase_one)
		else $error("frame start ignored");
	// Main scenarios
	cover property ($fell(vertical_phase_two));
	cover property ($fell(horizontal_phase_two));
	cover property (pix_valid && line_last);
endmodule // ccdrd_seq_asserts

bind ccdrd_seq ccdrd_seq_asserts i_chk (.core_clk(core_clk), .rst(rst), .frame_start(frame_start), .busy(busy),
	.vertical_phase_one(vertical_phase_one), .vertical_phase_two(vertical_phase_two),
	.horizontal_phase_one(horizontal_phase_one), .horizontal_phase_two(horizontal_phase_two),
	.reset_gate(reset_gate), .pix_valid(pix_valid), .line_last(line_last));

// ===== ccdrd_sensor_model.sv
`timescale 1ns/1ns
module ccdrd_sensor_model (
	// Reset and phase pins
	input  wire        rst,
	input  wire        vertical_phase_two,
	input  wire        horizontal_phase_two,
	input  wire        reset_gate,
	// Converted video
	output wire [11:0] video_sample
);
	logic [3:0]  line_reg = 4'hF;
	logic [7:0]  idx_reg = 8'h00;
	logic [11:0] node_reg = 12'h000;
	logic        v2_q = 1'b0;
	logic        h2_q = 1'b0;
	logic        rg_q = 1'b0;
	// One process owns all model state; edges found against last pin levels
	always @(rst or vertical_phase_two or horizontal_phase_two or reset_gate) begin
		if (rst) begin
			line_reg = 4'hF;
			idx_reg = 8'h00;
			node_reg = 12'h000;
		end else begin
			// Whole line lands in the shift register
			if (v2_q && !vertical_phase_two) begin
				line_reg = line_reg + 4'h1;
				idx_reg = 8'h00;
			end
			// Charge tagged by line and position
			if (h2_q && !horizontal_phase_two) begin
				node_reg = {line_reg, idx_reg};
				idx_reg = idx_reg + 8'h01;
			end
			if (!rg_q && reset_gate)
				node_reg = 12'h000; // Drain level
		end
		v2_q = vertical_phase_two;
		h2_q = horizontal_phase_two;
		rg_q = reset_gate;
	end
	assign video_sample = ~node_reg; // More charge, lower level
endmodule // ccdrd_sensor_model

// ===== ccdrd_seq_tb.sv
`timescale 1ns/1ns
module ccdrd_seq_tb;
	localparam ROWS = 6;
	localparam HLEN = 20;
	logic        core_clk = 0;
	logic        rst = 1;
	logic        frame_start = 0;
	wire         busy, v1, v2, h1, h2, rg, pix_valid, pix_active, pix_dark_ref, pix_first, line_last;
	wire  [11:0] video_sample, pix_data;
	int          err_total = 0, check_count = 0, k = 0, ln = 0, npix = 0, row = 0;
	logic        act, dref;
	ccdrd_seq #(.ROWS(ROWS), .HLEN(HLEN)) i_dut (.core_clk(core_clk), .rst(rst), .frame_start(frame_start),
		.busy(busy), .vertical_phase_one(v1), .vertical_phase_two(v2), .horizontal_phase_one(h1),
		.horizontal_phase_two(h2), .reset_gate(rg), .video_sample(video_sample), .pix_data(pix_data),
		.pix_valid(pix_valid), .pix_active(pix_active), .pix_dark_ref(pix_dark_ref), .pix_first(pix_first),
		.line_last(line_last));
	ccdrd_sensor_model i_sensor (.rst(rst), .vertical_phase_two(v2), .horizontal_phase_two(h2),
		.reset_gate(rg), .video_sample(video_sample));
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask
	task automatic finish_test;
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Judged mid-cycle, away from the edge that launches the pixel
	always @(negedge core_clk) begin
		if (pix_valid === 1'b1) begin
			row = ln % ROWS;
			// Active: after 10 dummies and 6 dark columns, after 4 dark lines
			act = (k >= 10 + 6) && (k < 10 + 6 + 3072) && (row >= 4) && (row < 4 + 2048);
			// Usable dark: real column, not active, not beside active, past first two lines
			dref = (row >= 2) && (row != 3) && (row != 4 + 2048) && (k >= 10) && (k < 10 + 3088) &&
			       (k != 15) && (k != 10 + 6 + 3072) && !act;
			check(pix_data, {ln[3:0], k[7:0]}, "pixel data");
			check({11'h000, line_last}, {11'h000, k == HLEN - 1}, "line end");
			check({11'h000, pix_active}, {11'h000, act}, "active flag");
			check({11'h000, pix_first}, {11'h000, (k == 0) && (row == 0)}, "first flag");
			check({11'h000, pix_dark_ref}, {11'h000, dref}, "dark ref flag");
			npix++;
			k = (k == HLEN - 1) ? 0 : k + 1;
			if (k == 0)
				ln++;
		end
	end
	task automatic wait_idle;
		int n;
		n = 0;
		@(posedge core_clk);
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		#1 check({11'h000, busy}, 12'h000, "frame hung");
	endtask
	// Start held for 300 cycles, well inside one frame, must not restart it
	task automatic t_frame(input logic hold);
		int base;
		base = npix;
		@(posedge core_clk);
		#1 frame_start = 1;
		repeat (hold ? 300 : 1) @(posedge core_clk);
		#1 frame_start = 0;
		wait_idle();
		check(12'(npix - base), 12'(ROWS * HLEN), "pixel count");
		check(12'(k), 12'h000, "partial line");
	endtask
	task automatic t_reset_mid;
		t_frame_kick();
		repeat (200) @(posedge core_clk);
		#1 rst = 1;
		repeat (2) @(posedge core_clk);
		#1 check({6'h00, busy, v1, v2, h1, h2, rg}, 12'h004, "reset pins");
		k = 0;
		ln = 0;
		rst = 0;
		repeat (40) @(posedge core_clk);
		#1 check({10'h000, v1, v2}, 12'h000, "idle vertical");
	endtask
	task automatic t_frame_kick;
		@(posedge core_clk);
		#1 frame_start = 1;
		@(posedge core_clk);
		#1 frame_start = 0;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		#1 rst = 0;
		t_frame(0);
		t_frame(1);
		t_reset_mid();
		t_frame(0);
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		finish_test();
	end
endmodule // ccdrd_seq_tb
